// ### core/ufc_flow_irq.sv
/*
 * UART flow control and interrupt logic for one channel, APB slave.
 * Assumes FIFO storage, shifters and line detectors sit outside and report
 * levels, received words and one-cycle events on the same clock.
 */
// Notes on behaviour
// - Two independent enables, bits 1:0 of flow config, for handshake.
// - Request-to-send drops when receive fill reaches stop threshold bits 3:0.
// - Request-to-send stays dropped until fill falls to restart threshold.
// - Stop and restart threshold crossings raise no interrupt.
// - With gating on, transmit only while clear-to-send input is low.
// - A character already started finishes before gating halts transmit.
// - Clear-to-send interrupt works; masked bit 7 reads zero always.
// - Fill at or above trigger level sets status bit 3 or 4.
// - Flow characters may be single byte or two-byte pairs.
// - Flow character receipt sets status bit 1, detail in special flags.
// - Config bits 5:4 enable compare; stop halts, resume restarts transmit.
// - Consumed flow characters are dropped, not written into receive FIFO.
// - Config bits 7:6 send stop at halt level, resume at restart.
// - In pair mode, first character goes out before the second.
// - Mode bit 7 makes interrupt pin active low on enabled pending.
// - After reset interrupt pin held low until init done, then high.
// - Reset clears all settings; host reprograms afterwards.
// - Status bits 2:0 point to misc, special and line detail.
// - Reading summary status clears bits 7 and 4:1; special and misc clear on read.
// - Line status clears only with its source; chip source read clears nothing.
`timescale 1ns/10ps
module ufc_flow_irq
    import ufc_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // FIFO levels and receive path.
    input wire logic [7:0] rxLevel,
    input wire logic [7:0] txLevel,
    input wire logic rxWordValid,
    input wire logic [7:0] rxWord,
    output logic rxPushValid,
    output logic [7:0] rxPushWord,
    output logic rxPop,
    // Line detail and misc events.
    input wire logic [7:0] lineCond,
    input wire logic [5:0] miscEvent,
    input wire logic specialEvent,
    // Transmitter handshake.
    input wire logic txCharBusy,
    input wire logic txCharDone,
    output logic txAllow,
    output logic ctlCharValid,
    output logic [7:0] ctlChar,
    input wire logic ctlCharTaken,
    // Pins.
    input wire logic clearToSendN,
    output logic requestToSendN,
    output logic irqN
);
    typedef struct packed {
        logic [7:0] flowCfg;
        logic [7:0] flow_threshold_reg;
        logic [7:0] fifoLvl;
        logic [7:0] mode_reg_one;
        logic [7:0] sumMask;
        logic [7:0] lineMask;
        logic [7:0] spMask;
        logic [7:0] miscMask;
        logic [7:0] resume1;
        logic [7:0] resume2;
        logic [7:0] stop1;
        logic [7:0] stop2;
        logic [4:1] sumSt;
        logic ctsSt;
        logic [5:0] spFlags;
        logic [5:0] miscFlags;
        logic rtsHeld;
        logic swHalted;
        logic rxOvfSent;
        logic pairSeen;
        logic [7:0] pairFirst;
        logic ctsS1;
        logic ctsS2;
        logic ctsLast;
        logic gateOpen;
        ufc_ctl_e ctl;
        logic [7:0] ctlSecond;
        logic [9:0] initCnt;
        logic initDone;
        logic [31:0] rdata;
        logic rxPop;
        logic rdy;
        ufc_byte_s push;
    } ufc_state_s;

    ufc_state_s st_r;
    ufc_state_s st_nxt;

    function automatic logic addrIs(input logic [11:0] a, input logic [7:0] idx);
        addrIs = (a[11:2] == {2'h0, idx});
    endfunction : addrIs

    logic access;
    logic rdEn;
    logic wrEn;
    logic [7:0] sumView;
    logic [5:0] spRaw;
    logic pending;
    logic isStop1;
    logic isResume1;
    logic pairMode;
    logic [7:0] wb;
    logic mapped;

    assign access = psel && penable;
    assign rdEn = access && !pwrite && !st_r.rdy;
    assign wrEn = access && pwrite && st_r.rdy;
    assign wb = pwdata[7:0];
    assign pairMode = st_r.flowCfg[3];
    assign isStop1 = rxWord == st_r.stop1;
    assign isResume1 = rxWord == st_r.resume1;

    // Summary view: masked CTS reads zero, bits 2:0 point to detail.
    always_comb begin
        sumView = 8'h00;
        sumView[BIT_CTS_IRQ] = st_r.ctsSt && st_r.sumMask[BIT_CTS_IRQ];
        sumView[BIT_TX_TRIG] = st_r.sumSt[4];
        sumView[BIT_RX_TRIG] = st_r.sumSt[3];
        sumView[BIT_MISC_PTR] = st_r.sumSt[2];
        sumView[BIT_SPECIAL_PTR] = st_r.sumSt[1];
        sumView[BIT_LINE_PTR] = |(lineCond & st_r.lineMask);
    end

    assign pending = |(sumView & st_r.sumMask);
    assign mapped = addrIs(paddr, IDX_SUMMARY_MASK) || addrIs(paddr, IDX_SUMMARY_STATUS)
        || addrIs(paddr, IDX_LINE_MASK) || addrIs(paddr, IDX_LINE_STATUS)
        || addrIs(paddr, IDX_SPECIAL_MASK) || addrIs(paddr, IDX_SPECIAL_FLAGS)
        || addrIs(paddr, IDX_MISC_MASK) || addrIs(paddr, IDX_MISC_FLAGS)
        || addrIs(paddr, IDX_MODE_ONE) || addrIs(paddr, IDX_FLOW_THRESHOLD)
        || addrIs(paddr, IDX_FIFO_THRESHOLD) || addrIs(paddr, IDX_TX_LEVEL)
        || addrIs(paddr, IDX_RX_LEVEL) || addrIs(paddr, IDX_FLOW_CONFIG)
        || addrIs(paddr, IDX_RESUME_FIRST) || addrIs(paddr, IDX_RESUME_SECOND)
        || addrIs(paddr, IDX_STOP_FIRST) || addrIs(paddr, IDX_STOP_SECOND)
        || addrIs(paddr, IDX_CHIP_IRQ) || addrIs(paddr, IDX_RX_POP);

    always_comb begin
        st_nxt = st_r;
        spRaw = 6'h00;
        st_nxt.rxPop = 1'b0;
        st_nxt.push = '0;
        st_nxt.rdy = access && !st_r.rdy;
        st_nxt.ctsS1 = clearToSendN;
        st_nxt.ctsS2 = st_r.ctsS1;
        st_nxt.ctsLast = st_r.ctsS2;
        if (!st_r.initDone) begin
            st_nxt.initCnt = st_r.initCnt + 10'h001;
            if (st_r.initCnt == 10'(INIT_CYCLES - 1)) begin
                st_nxt.initDone = 1'b1;
            end
        end
        // Receive handshake hysteresis, no interrupt involved.
        if (rxLevel >= {4'h0, st_r.flow_threshold_reg[3:0]}) begin
            st_nxt.rtsHeld = 1'b1;
        end else if (rxLevel <= {4'h0, st_r.flow_threshold_reg[7:4]}) begin
            st_nxt.rtsHeld = 1'b0;
        end
        // Gate changes only between characters.
        if (!txCharBusy || txCharDone) begin
            st_nxt.gateOpen = !(st_r.flowCfg[BIT_AUTO_TX_GATE] && st_r.ctsS2)
                && !st_r.swHalted;
        end
        // Receive path: compare and filter flow characters.
        if (rxWordValid) begin
            if (|st_r.flowCfg[5:4]) begin
                if (pairMode && st_r.pairSeen) begin
                    st_nxt.pairSeen = 1'b0;
                    if (st_r.pairFirst == st_r.stop1 && rxWord == st_r.stop2) begin
                        st_nxt.swHalted = 1'b1;
                        spRaw[3] = 1'b1;
                    end else if (st_r.pairFirst == st_r.resume1
                                 && rxWord == st_r.resume2) begin
                        st_nxt.swHalted = 1'b0;
                        spRaw[1] = 1'b1;
                    end else begin
                        st_nxt.push = '{word: rxWord, valid: 1'b1};
                    end
                end else if (pairMode && (isStop1 || isResume1)) begin
                    st_nxt.pairSeen = 1'b1;
                    st_nxt.pairFirst = rxWord;
                end else if (!pairMode && isStop1) begin
                    st_nxt.swHalted = 1'b1;
                    spRaw[2] = 1'b1;
                end else if (!pairMode && isResume1) begin
                    st_nxt.swHalted = 1'b0;
                    spRaw[0] = 1'b1;
                end else begin
                    st_nxt.push = '{word: rxWord, valid: 1'b1};
                end
            end else begin
                st_nxt.push = '{word: rxWord, valid: 1'b1};
            end
        end
        // Receive overflow: send stop or resume, first before second.
        case (st_r.ctl)
            TX_IDLE: begin
                if (|st_r.flowCfg[7:6]) begin
                    if (!st_r.rxOvfSent && rxLevel >= {4'h0, st_r.flow_threshold_reg[3:0]}) begin
                        st_nxt.rxOvfSent = 1'b1;
                        st_nxt.ctl = TX_FIRST;
                        st_nxt.ctlSecond = st_r.stop2;
                    end else if (st_r.rxOvfSent
                                 && rxLevel <= {4'h0, st_r.flow_threshold_reg[7:4]}) begin
                        st_nxt.rxOvfSent = 1'b0;
                        st_nxt.ctl = TX_FIRST;
                        st_nxt.ctlSecond = st_r.resume2;
                    end
                end
            end
            TX_FIRST: begin
                if (ctlCharTaken) begin
                    st_nxt.ctl = pairMode ? TX_SECOND : TX_IDLE;
                end
            end
            TX_SECOND: begin
                if (ctlCharTaken) begin
                    st_nxt.ctl = TX_IDLE;
                end
            end
            default: st_nxt.ctl = TX_IDLE;
        endcase
        // Sticky events; a set wins over a read clear.
        if (rdEn && addrIs(paddr, IDX_SUMMARY_STATUS)) begin
            st_nxt.sumSt = 4'h0;
            st_nxt.ctsSt = 1'b0;
        end
        if (rdEn && addrIs(paddr, IDX_SPECIAL_FLAGS)) begin
            st_nxt.spFlags = 6'h00;
        end
        if (rdEn && addrIs(paddr, IDX_MISC_FLAGS)) begin
            st_nxt.miscFlags = 6'h00;
        end
        if (txLevel >= {4'h0, st_r.fifoLvl[3:0]} && |st_r.fifoLvl[3:0]) begin
            st_nxt.sumSt[4] = 1'b1;
        end
        if (rxLevel >= {4'h0, st_r.fifoLvl[7:4]} && |st_r.fifoLvl[7:4]) begin
            st_nxt.sumSt[3] = 1'b1;
        end
        if (st_r.ctsS2 != st_r.ctsLast && st_r.sumMask[BIT_CTS_IRQ]) begin
            st_nxt.ctsSt = 1'b1;
        end
        st_nxt.spFlags = st_nxt.spFlags | spRaw | {specialEvent, 5'h00};
        st_nxt.miscFlags = st_nxt.miscFlags | miscEvent;
        if (|((spRaw | {specialEvent, 5'h00}) & st_r.spMask[5:0])) begin
            st_nxt.sumSt[1] = 1'b1;
        end
        if (|(miscEvent & st_r.miscMask[5:0])) begin
            st_nxt.sumSt[2] = 1'b1;
        end
        // Register writes, effective at the APB access edge.
        if (wrEn) begin
            if (addrIs(paddr, IDX_SUMMARY_MASK)) st_nxt.sumMask = wb;
            else if (addrIs(paddr, IDX_LINE_MASK)) st_nxt.lineMask = wb;
            else if (addrIs(paddr, IDX_SPECIAL_MASK)) st_nxt.spMask = wb;
            else if (addrIs(paddr, IDX_MISC_MASK)) st_nxt.miscMask = wb;
            else if (addrIs(paddr, IDX_MODE_ONE)) st_nxt.mode_reg_one = wb;
            else if (addrIs(paddr, IDX_FLOW_THRESHOLD)) st_nxt.flow_threshold_reg = wb;
            else if (addrIs(paddr, IDX_FIFO_THRESHOLD)) st_nxt.fifoLvl = wb;
            else if (addrIs(paddr, IDX_FLOW_CONFIG)) st_nxt.flowCfg = wb;
            else if (addrIs(paddr, IDX_RESUME_FIRST)) st_nxt.resume1 = wb;
            else if (addrIs(paddr, IDX_RESUME_SECOND)) st_nxt.resume2 = wb;
            else if (addrIs(paddr, IDX_STOP_FIRST)) st_nxt.stop1 = wb;
            else if (addrIs(paddr, IDX_STOP_SECOND)) st_nxt.stop2 = wb;
        end
        // Read data is captured one cycle before pready and stands with it.
        st_nxt.rdata = 32'h0000_0000;
        if (rdEn) begin
            if (addrIs(paddr, IDX_SUMMARY_MASK)) st_nxt.rdata[7:0] = st_r.sumMask;
            else if (addrIs(paddr, IDX_SUMMARY_STATUS)) st_nxt.rdata[7:0] = sumView;
            else if (addrIs(paddr, IDX_LINE_MASK)) st_nxt.rdata[7:0] = st_r.lineMask;
            else if (addrIs(paddr, IDX_LINE_STATUS)) st_nxt.rdata[7:0] = lineCond;
            else if (addrIs(paddr, IDX_SPECIAL_MASK)) st_nxt.rdata[7:0] = st_r.spMask;
            else if (addrIs(paddr, IDX_SPECIAL_FLAGS))
                st_nxt.rdata[7:0] = {2'h0, st_r.spFlags};
            else if (addrIs(paddr, IDX_MISC_MASK)) st_nxt.rdata[7:0] = st_r.miscMask;
            else if (addrIs(paddr, IDX_MISC_FLAGS))
                st_nxt.rdata[7:0] = {2'h0, st_r.miscFlags};
            else if (addrIs(paddr, IDX_MODE_ONE)) st_nxt.rdata[7:0] = st_r.mode_reg_one;
            else if (addrIs(paddr, IDX_FLOW_THRESHOLD)) st_nxt.rdata[7:0] = st_r.flow_threshold_reg;
            else if (addrIs(paddr, IDX_FIFO_THRESHOLD)) st_nxt.rdata[7:0] = st_r.fifoLvl;
            else if (addrIs(paddr, IDX_TX_LEVEL)) st_nxt.rdata[7:0] = txLevel;
            else if (addrIs(paddr, IDX_RX_LEVEL)) st_nxt.rdata[7:0] = rxLevel;
            else if (addrIs(paddr, IDX_FLOW_CONFIG)) st_nxt.rdata[7:0] = st_r.flowCfg;
            else if (addrIs(paddr, IDX_RESUME_FIRST)) st_nxt.rdata[7:0] = st_r.resume1;
            else if (addrIs(paddr, IDX_RESUME_SECOND)) st_nxt.rdata[7:0] = st_r.resume2;
            else if (addrIs(paddr, IDX_STOP_FIRST)) st_nxt.rdata[7:0] = st_r.stop1;
            else if (addrIs(paddr, IDX_STOP_SECOND)) st_nxt.rdata[7:0] = st_r.stop2;
            else if (addrIs(paddr, IDX_CHIP_IRQ))
                st_nxt.rdata[7:0] = {7'h00, pending};
            else if (addrIs(paddr, IDX_RX_POP)) begin
                st_nxt.rxPop = 1'b1;
            end
        end
    end

    // Reset returns every setting to zero; host reprograms.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Transmitter is held off by mode bit 1 set by host.
    assign txAllow = st_r.gateOpen && !st_r.mode_reg_one[BIT_TX_DISABLE];
    assign requestToSendN = st_r.flowCfg[BIT_AUTO_RX_HS] ? st_r.rtsHeld : 1'b0;
    assign ctlCharValid = st_r.ctl != TX_IDLE;
    assign ctlChar = (st_r.ctl == TX_SECOND) ? st_r.ctlSecond
        : (st_r.ctlSecond == st_r.stop2 && st_r.rxOvfSent) ? st_r.stop1 : st_r.resume1;
    // Low until init, then high; active-low pending once selected.
    assign irqN = !st_r.initDone ? 1'b0
        : st_r.mode_reg_one[BIT_IRQ_SELECT] ? !pending : 1'b1;
    assign rxPushValid = st_r.push.valid;
    assign rxPushWord = st_r.push.word;
    assign rxPop = st_r.rxPop;
    assign prdata = st_r.rdata;
    assign pready = access && st_r.rdy;
    assign pslverr = pready && !mapped;

    stop_holds_a: assert property (@(posedge core_clk) disable iff (reset)
        st_r.flowCfg[0] && rxLevel >= {4'h0, st_r.flow_threshold_reg[3:0]}
        |=> requestToSendN) else $error("stop level did not drop handshake");
    init_low_a: assert property (@(posedge core_clk) disable iff (reset)
        !st_r.initDone |-> !irqN) else $error("irq high before init");
    cts_mask_a: assert property (@(posedge core_clk) disable iff (reset)
        !st_r.sumMask[7] |-> !sumView[7]) else $error("masked cts visible");
    gate_char_a: assert property (@(posedge core_clk) disable iff (reset)
        txCharBusy && !txCharDone |=> $stable(st_r.gateOpen))
        else $error("gate changed mid character");
    rd_clear_a: assert property (@(posedge core_clk) disable iff (reset)
        rdEn && addrIs(paddr, IDX_MISC_FLAGS) && miscEvent == 6'h00
        |=> st_r.miscFlags == 6'h00) else $error("misc not cleared");
    flow_drop_a: assert property (@(posedge core_clk)
        disable iff (reset)
        rxWordValid && |st_r.flowCfg[5:4] && !pairMode
        && (isStop1 || isResume1) |=> !rxPushValid)
        else $error("flow character pushed");
endmodule : ufc_flow_irq

// ### core/ufc_pkg.sv
/*
 * Shared constants and carrier types for the UART flow control and
 * interrupt block. Assumes a 32-bit APB register bus, one word per register.
 */
package ufc_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_SUMMARY_MASK = 8'h01;
    localparam logic [7:0] IDX_SUMMARY_STATUS = 8'h02;
    localparam logic [7:0] IDX_LINE_MASK = 8'h03;
    localparam logic [7:0] IDX_LINE_STATUS = 8'h04;
    localparam logic [7:0] IDX_SPECIAL_MASK = 8'h05;
    localparam logic [7:0] IDX_SPECIAL_FLAGS = 8'h06;
    localparam logic [7:0] IDX_MISC_MASK = 8'h07;
    localparam logic [7:0] IDX_MISC_FLAGS = 8'h08;
    localparam logic [7:0] IDX_MODE_ONE = 8'h09;
    localparam logic [7:0] IDX_FLOW_THRESHOLD = 8'h0f;
    localparam logic [7:0] IDX_FIFO_THRESHOLD = 8'h10;
    localparam logic [7:0] IDX_TX_LEVEL = 8'h11;
    localparam logic [7:0] IDX_RX_LEVEL = 8'h12;
    localparam logic [7:0] IDX_FLOW_CONFIG = 8'h13;
    localparam logic [7:0] IDX_RESUME_FIRST = 8'h14;
    localparam logic [7:0] IDX_RESUME_SECOND = 8'h15;
    localparam logic [7:0] IDX_STOP_FIRST = 8'h16;
    localparam logic [7:0] IDX_STOP_SECOND = 8'h17;
    localparam logic [7:0] IDX_CHIP_IRQ = 8'h1f;
    localparam logic [7:0] IDX_RX_POP = 8'h00;
    // Field positions.
    localparam int BIT_AUTO_RX_HS = 0;
    localparam int BIT_AUTO_TX_GATE = 1;
    localparam int BIT_TX_DISABLE = 1;
    localparam int BIT_IRQ_SELECT = 7;
    localparam int BIT_CTS_IRQ = 7;
    localparam int BIT_TX_TRIG = 4;
    localparam int BIT_RX_TRIG = 3;
    localparam int BIT_MISC_PTR = 2;
    localparam int BIT_SPECIAL_PTR = 1;
    localparam int BIT_LINE_PTR = 0;
    localparam int BIT_SW_TX_LO = 4;
    localparam int BIT_SW_RX_LO = 6;
    // Reset values and timing.
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam int INIT_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int INIT_CYCLES =
        (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] FIFO_MAX = 8'h80;

    typedef enum logic [1:0] {TX_IDLE, TX_FIRST, TX_SECOND} ufc_ctl_e;

    typedef struct packed {
        logic [7:0] word;
        logic valid;
    } ufc_byte_s;
endpackage : ufc_pkg

// ### dv/ufc_far_model.sv
/*
 * Far-side model: receive FIFO fill counter, transmit shifter and flow
 * character sink. Assumes the block under test runs on the same clock.
 */
`timescale 1ns/10ps
module ufc_far_model
    import ufc_pkg::*;
#(
    parameter int CHAR_CYCLES = 10
)
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Receive FIFO side.
    input wire logic rxPushValid,
    input wire logic rxPop,
    output logic [7:0] rxLevel,
    // Transmit side.
    input wire logic txAllow,
    input wire logic [7:0] txLevel,
    output logic txCharBusy,
    output logic txCharDone,
    input wire logic ctlCharValid,
    input wire logic [7:0] ctlChar,
    output logic ctlCharTaken
);
    logic [7:0] ctlSeen[$];
    int busyLeft;

    always @(posedge core_clk) begin
        if (reset) begin
            rxLevel <= 8'h00;
            txCharBusy <= 1'b0;
            txCharDone <= 1'b0;
            ctlCharTaken <= 1'b0;
            busyLeft <= 0;
            ctlSeen.delete();
        end else begin
            rxLevel <= rxLevel + 8'(rxPushValid) - 8'(rxPop);
            txCharDone <= 1'b0;
            ctlCharTaken <= 1'b0;
            // A started character always runs to its end.
            if (txCharBusy) begin
                busyLeft <= busyLeft - 1;
                if (busyLeft == 1) begin
                    txCharBusy <= 1'b0;
                    txCharDone <= 1'b1;
                end
            end else if (ctlCharValid && !ctlCharTaken) begin
                ctlCharTaken <= 1'b1;
                ctlSeen.push_back(ctlChar);
            end else if (txAllow && txLevel != 8'h00) begin
                txCharBusy <= 1'b1;
                busyLeft <= CHAR_CYCLES;
            end
        end
    end
endmodule : ufc_far_model

// ### dv/tb_top.sv
/*
 * Self-checking bench for the flow control and interrupt block.
 * Assumes the design package and the far-side model are compiled first.
 */
`timescale 1ns/10ps
module tb_top
    import ufc_pkg::*;
;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [7:0] rxLevel, txLevel, rxWord, rxPushWord, lineCond, ctlChar;
    logic rxWordValid, rxPushValid, rxPop, txCharBusy, txCharDone, txAllow;
    logic ctlCharValid, ctlCharTaken, clearToSendN, requestToSendN, irqN;
    int nMismatch = 0, comparisons = 0, cycles = 0, pushCnt = 0, p0, p1;
    logic [7:0] lastPush;
    localparam logic [7:0] CH [4] = '{8'h13, 8'h93, 8'h11, 8'h91};

    ufc_flow_irq uut (.core_clk(core_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxLevel(rxLevel), .txLevel(txLevel), .rxWordValid(rxWordValid),
        .rxWord(rxWord), .rxPushValid(rxPushValid), .rxPushWord(rxPushWord),
        .rxPop(rxPop), .lineCond(lineCond), .miscEvent(6'h00),
        .specialEvent(1'b0), .txCharBusy(txCharBusy),
        .txCharDone(txCharDone), .txAllow(txAllow),
        .ctlCharValid(ctlCharValid), .ctlChar(ctlChar),
        .ctlCharTaken(ctlCharTaken), .clearToSendN(clearToSendN),
        .requestToSendN(requestToSendN), .irqN(irqN));

    ufc_far_model far (.core_clk(core_clk), .reset(reset),
        .rxPushValid(rxPushValid), .rxPop(rxPop), .rxLevel(rxLevel),
        .txAllow(txAllow), .txLevel(txLevel), .txCharBusy(txCharBusy),
        .txCharDone(txCharDone), .ctlCharValid(ctlCharValid),
        .ctlChar(ctlChar), .ctlCharTaken(ctlCharTaken));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (rxPushValid === 1'b1) begin
            pushCnt <= pushCnt + 1;
            lastPush <= rxPushWord;
        end
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            nMismatch++;
            wrapUp();
        end
    end

    task automatic chk(input logic [31:0] got, exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // One APB transfer; read data and the error flag are taken at the edge
    // that samples pready high, and only then is the request released.
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        e = pslverr;
        d = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string msg);
        apb(1'b0, idx, 32'h0);
        chk(d, exp, msg);
    endtask : rd

    task automatic waitSig(ref logic s, input logic v, input string msg);
        int k;
        k = 0;
        while (s !== v && k < 400) begin
            k++;
            @(posedge core_clk);
            #1;
        end
        p0 = k;
        chk({31'b0, s}, {31'b0, v}, msg);
    endtask : waitSig

    task automatic rxIn(input logic [7:0] w);
        @(posedge core_clk);
        rxWordValid <= 1'b1;
        rxWord <= w;
        @(posedge core_clk);
        rxWordValid <= 1'b0;
    endtask : rxIn

    task automatic waitQ(input int k);
        int j;
        j = 0;
        while (far.ctlSeen.size() < k && j < 400) begin
            j++;
            @(posedge core_clk);
        end
    endtask : waitQ

    task automatic wrapUp();
        if (nMismatch == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrapUp

    initial begin
        {psel, penable, pwrite, rxWordValid} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        rxWord = 8'h00;
        txLevel = 8'h00;
        lineCond = 8'h00;
        clearToSendN = 1'b0;
        reset = 1'b1;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1 chk({31'b0, irqN}, 32'h0, "irq held low");
        waitSig(irqN, 1'b1, "irq ready");
        chk({31'b0, p0 > INIT_CYCLES - 4 && p0 < INIT_CYCLES + 4}, 32'h1, "init time");
        rd(IDX_FLOW_CONFIG, 32'h0, "flow cfg reset");
        // Receive handshake with halt 4 and resume 2.
        wr(IDX_FLOW_THRESHOLD, 32'h24);
        wr(IDX_FLOW_CONFIG, 32'h01);
        repeat (3) rxIn(8'h41);
        rd(IDX_RX_LEVEL, 32'h3, "rx level");
        chk({31'b0, requestToSendN}, 32'h0, "rts below halt");
        rxIn(8'h42);
        waitSig(requestToSendN, 1'b1, "rts at halt");
        rd(IDX_SUMMARY_STATUS, 32'h0, "no threshold irq");
        apb(1'b0, IDX_RX_POP, 32'h0);
        rd(IDX_RX_LEVEL, 32'h3, "rx level");
        chk({31'b0, requestToSendN}, 32'h1, "rts held");
        apb(1'b0, IDX_RX_POP, 32'h0);
        waitSig(requestToSendN, 1'b0, "rts resumed");
        // Receive overflow control with character pairs.
        for (int i = 0; i < 4; i++)
            wr(IDX_STOP_FIRST - 8'(i / 2 * 2) + 8'(i % 2), {24'h0, CH[i]});
        wr(IDX_FLOW_CONFIG, 32'hc8);
        repeat (2) rxIn(8'h43);
        waitQ(2);
        repeat (2) apb(1'b0, IDX_RX_POP, 32'h0);
        waitQ(4);
        chk(far.ctlSeen.size(), 32'h4, "flow char count");
        for (int i = 0; i < 4 && i < far.ctlSeen.size(); i++)
            chk({24'h0, far.ctlSeen[i]}, {24'h0, CH[i]}, "flow char");
        // Transmit software flow control.
        wr(IDX_MODE_ONE, 32'h02);
        wr(IDX_FLOW_CONFIG, 32'h30);
        wr(IDX_SPECIAL_MASK, 32'h3f);
        wr(IDX_SUMMARY_MASK, 32'h02);
        wr(IDX_MODE_ONE, 32'h00);
        @(posedge core_clk) txLevel <= 8'h05;
        waitSig(txAllow, 1'b1, "tx allowed");
        p1 = pushCnt;
        rxIn(CH[0]);
        waitSig(txAllow, 1'b0, "stop halts tx");
        rd(IDX_SUMMARY_STATUS, 32'h02, "special summary");
        rd(IDX_SUMMARY_STATUS, 32'h00, "summary cleared");
        rxIn(CH[2]);
        waitSig(txAllow, 1'b1, "resume restarts tx");
        rd(IDX_SUMMARY_STATUS, 32'h02, "special summary");
        rd(IDX_SPECIAL_FLAGS, 32'h05, "special detail");
        rd(IDX_SPECIAL_FLAGS, 32'h00, "special cleared");
        chk(pushCnt, 32'(p1), "flow chars dropped");
        chk({24'h0, lastPush}, 32'h43, "last pushed word");
        // Clear-to-send gating and its interrupt.
        wr(IDX_MODE_ONE, 32'h02);
        wr(IDX_FLOW_CONFIG, 32'h02);
        wr(IDX_SUMMARY_MASK, 32'h80);
        wr(IDX_MODE_ONE, 32'h80);
        @(posedge core_clk) clearToSendN <= 1'b1;
        waitSig(txAllow, 1'b0, "cts high stops tx");
        waitSig(irqN, 1'b0, "irq asserted");
        rd(IDX_CHIP_IRQ, 32'h1, "chip source");
        chk({31'b0, irqN}, 32'h0, "chip read keeps irq");
        rd(IDX_SUMMARY_STATUS, 32'h80, "cts summary");
        waitSig(irqN, 1'b1, "irq cleared");
        @(posedge core_clk) clearToSendN <= 1'b0;
        waitSig(txAllow, 1'b1, "cts low allows tx");
        rd(IDX_SUMMARY_STATUS, 32'h80, "cts summary");
        wr(IDX_SUMMARY_MASK, 32'h00);
        @(posedge core_clk) clearToSendN <= 1'b1;
        waitSig(txAllow, 1'b0, "cts high stops tx");
        rd(IDX_SUMMARY_STATUS, 32'h00, "masked cts");
        chk({31'b0, irqN}, 32'h1, "masked no irq");
        @(posedge core_clk) clearToSendN <= 1'b0;
        // Transmit trigger level at its boundary.
        wr(IDX_SUMMARY_MASK, 32'h10);
        wr(IDX_FIFO_THRESHOLD, 32'h06);
        rd(IDX_SUMMARY_STATUS, 32'h00, "below trigger");
        @(posedge core_clk) txLevel <= 8'h06;
        rd(IDX_SUMMARY_STATUS, 32'h10, "at trigger");
        // Line status is level held and not cleared by a read.
        @(posedge core_clk) lineCond <= 8'h02;
        repeat (2) begin
            apb(1'b0, IDX_LINE_STATUS, 32'h0);
            chk(d & 32'h7f, 32'h02, "line status");
        end
        @(posedge core_clk) lineCond <= 8'h00;
        apb(1'b0, IDX_LINE_STATUS, 32'h0);
        chk(d & 32'h7f, 32'h00, "line status gone");
        apb(1'b0, 8'h3c, 32'h0);
        chk({31'b0, e}, 32'h1, "unmapped error");
        // A reset in mid-run drops all settings.
        @(posedge core_clk) reset <= 1'b1;
        @(posedge core_clk) reset <= 1'b0;
        #1 chk({31'b0, irqN}, 32'h0, "irq low after reset");
        rd(IDX_FLOW_CONFIG, 32'h0, "settings lost");
        wrapUp();
    end
endmodule : tb_top
